// ---- design/pss_defines.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the step sequencer
// Assumes: 20 MHz module clock, AHB-Lite register port with 32-bit data
// Notes:   definitions only
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// register byte offsets
`define PSS_OFF_CTRL      8'h00
`define PSS_OFF_REP_STEP  8'h04
`define PSS_OFF_STATUS    8'h08
`define PSS_OFF_IRQ_STAT  8'h0C
`define PSS_OFF_IRQ_MASK  8'h10
`define PSS_OFF_TBL_INDEX 8'h14
`define PSS_OFF_TBL_GOAL  8'h18
`define PSS_OFF_TBL_CFG   8'h1C
`define PSS_OFF_TBL_DWELL 8'h20
`define PSS_OFF_POSITION  8'h24

// field positions
`define PSS_CTRL_START_BIT   0
`define PSS_IRQ_DONE_BIT     0
`define PSS_IRQ_ERR_BIT      1
`define PSS_CFG_METHOD_BIT   2
`define PSS_CFG_SPDCTL_BIT   3
`define PSS_REP_PENDING_BIT  8

// step table limits and chain limit
`define PSS_STEP_MAX    8'h96
`define PSS_STEP_FIRST  8'h01
`define PSS_CHAIN_MAX   9'h190

// error codes
`define PSS_ERR_NONE      10'h000
`define PSS_ERR_SPD_BLEND 10'h0EC
`define PSS_ERR_DIR_FLIP  10'h1FF
`define PSS_ERR_CHAIN     10'h0E0

// reset values
`define PSS_RST_STEP  8'h01
`define PSS_RST_IRQ   2'h0

// timing: dwell and profile update run on a 1 ms tick
`define PSS_CLK_PERIOD_NS 50
`define PSS_MS_NS         1000000
`define PSS_MS_CYCLES     (`PSS_MS_NS / `PSS_CLK_PERIOD_NS)

`endif

// ---- design/pss_pkg.sv ----
// Purpose: types shared by the step sequencer and its bench
// Assumes: pss_defines.svh holds the numbers
// Notes:   types only
package pss_pkg;

  // operation pattern of one step
  typedef enum logic [1:0] {
    PSS_PAT_END             = 2'h0,
    PSS_PAT_KEEP            = 2'h1,
    PSS_PATTERN_BLEND_NEXT_STEP = 2'h2
  } pss_pattern_e;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    PSS_ST_IDLE  = 4'h1,
    PSS_ST_LOAD  = 4'h2,
    PSS_ST_MOVE  = 4'h4,
    PSS_ST_DWELL = 4'h8
  } pss_state_e;

  // one positioning step
  typedef struct packed {
    logic [31:0]  goal;          // signed absolute goal address
    logic [15:0]  speed;         // pulses per ms
    logic [15:0]  dwell;         // ms
    pss_pattern_e pattern;
    logic         method_repeat; // 0 = method_single_pass
    logic         speed_ctl;     // speed-control step
  } pss_step_s;

  // captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [7:0] addr;
  } pss_ahb_cap_s;

  // command toward the servo drive
  typedef struct packed {
    logic        moving;
    logic        dir_fwd;
    logic [15:0] rate;
    logic [31:0] position;
  } pss_motion_s;

endpackage : pss_pkg

// ---- design/pss_sequencer.sv ----
// Purpose: per-axis positioning step sequencer with AHB-Lite registers
// Assumes: one clock hclk at 20 MHz, asynchronous active-low hresetn
// Notes:   profile and dwell advance once per 1 ms tick
`timescale 1ns/100ps
`default_nettype none
`include "pss_defines.svh"

module pss_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `PSS_MS_CYCLES  // cycles per 1 ms tick
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output pss_motion_s      motion,
  output logic             busy,
  output logic             done_pulse,
  output logic             irq
);

  // next step number, wrapping past the last step
  function automatic logic [7:0] step_plus_one(input logic [7:0] s);
    step_plus_one = (s >= `PSS_STEP_MAX) ? `PSS_STEP_FIRST : s + 8'h01;
  endfunction : step_plus_one

  // valid step number test
  function automatic logic step_ok(input logic [7:0] s);
    step_ok = (s != 8'h00) && (s <= `PSS_STEP_MAX);
  endfunction : step_ok

  // storage
  pss_step_s    table_reg [1:150];   // step table, index = step number
  pss_ahb_cap_s cap_reg;             // address phase held into the data phase
  logic [31:0]  hrdata_reg;          // read data, loaded at the address phase
  pss_state_e   state_reg;           // sequencer state
  logic [7:0]   cur_step_reg;        // current step number
  logic [7:0]   run_step_reg;        // step being executed
  logic [7:0]   start_step_reg;      // step field of the last control write
  logic [7:0]   rep_val_reg;         // repeat-change target
  logic         rep_pend_reg;        // repeat-change issued, not yet used
  logic [7:0]   tbl_idx_reg;         // table write index
  logic [31:0]  tbl_goal_reg;        // staged goal
  logic [15:0]  tbl_dwell_reg;       // staged dwell
  pss_step_s    act_reg;             // latched copy of the running step
  logic         prev_blend_reg;      // previous step was a blend step
  logic [8:0]   chain_cnt_reg;       // steps executed since the start
  logic [15:0]  vel_reg;             // present speed, pulses per ms
  logic signed [31:0] pos_reg;       // commanded position
  logic         dir_reg;             // 1 = forward
  logic [15:0]  dwell_cnt_reg;       // ms left in dwell
  logic [31:0]  ms_cnt_reg;          // tick prescaler
  logic [9:0]   err_code_reg;        // last error code
  logic [1:0]   irq_stat_reg;        // sticky events
  logic [1:0]   irq_mask_reg;        // event enables
  logic         done_reg;            // completion pulse
  pss_motion_s  motion_reg;          // drive command

  // bus decode
  wire        addr_ok  = hsel & htrans[1] & hready;
  wire        wr_ok    = cap_reg.valid & cap_reg.wr;
  wire [7:0]  rd_addr  = haddr[7:0];
  wire        wr_ctrl  = wr_ok && (cap_reg.addr == `PSS_OFF_CTRL);
  wire        wr_rep   = wr_ok && (cap_reg.addr == `PSS_OFF_REP_STEP);
  wire        wr_istat = wr_ok && (cap_reg.addr == `PSS_OFF_IRQ_STAT);
  wire        wr_imask = wr_ok && (cap_reg.addr == `PSS_OFF_IRQ_MASK);
  wire        wr_tidx  = wr_ok && (cap_reg.addr == `PSS_OFF_TBL_INDEX);
  wire        wr_tgoal = wr_ok && (cap_reg.addr == `PSS_OFF_TBL_GOAL);
  wire        wr_tcfg  = wr_ok && (cap_reg.addr == `PSS_OFF_TBL_CFG);
  wire        wr_tdwl  = wr_ok && (cap_reg.addr == `PSS_OFF_TBL_DWELL);
  wire [7:0]  wr_step  = hwdata[15:8];
  // a start is taken only when idle and naming 0 or a valid step
  wire        start_ok = wr_ctrl && hwdata[`PSS_CTRL_START_BIT] &&
                         (state_reg == PSS_ST_IDLE) &&
                         ((wr_step == 8'h00) || step_ok(wr_step));

  // read mux, address phase offsets
  logic [31:0] rd_mux;
  always_comb
  begin
    if (rd_addr == `PSS_OFF_CTRL)
      rd_mux = {16'h0000, start_step_reg, 8'h00};
    else if (rd_addr == `PSS_OFF_REP_STEP)
      rd_mux = {23'h000000, rep_pend_reg, rep_val_reg};
    else if (rd_addr == `PSS_OFF_STATUS)
      rd_mux = {6'h00, err_code_reg, cur_step_reg, 7'h00, busy};
    else if (rd_addr == `PSS_OFF_IRQ_STAT)
      rd_mux = {30'h00000000, irq_stat_reg};
    else if (rd_addr == `PSS_OFF_IRQ_MASK)
      rd_mux = {30'h00000000, irq_mask_reg};
    else if (rd_addr == `PSS_OFF_TBL_INDEX)
      rd_mux = {24'h000000, tbl_idx_reg};
    else if (rd_addr == `PSS_OFF_TBL_GOAL)
      rd_mux = tbl_goal_reg;
    else if (rd_addr == `PSS_OFF_TBL_DWELL)
      rd_mux = {16'h0000, tbl_dwell_reg};
    else if (rd_addr == `PSS_OFF_POSITION)
      rd_mux = pos_reg;
    else
      rd_mux = 32'h00000000;  // unmapped and write-only read as zero
  end

  // one ms tick from a free prescaler
  wire ms_tick = (ms_cnt_reg == MS_CYCLES - 1);

  // step about to be loaded
  wire pss_step_s ld = table_reg[step_ok(run_step_reg) ? run_step_reg : `PSS_STEP_FIRST];
  // direction of the new step from its goal address only
  wire ld_fwd  = ($signed(ld.goal) > pos_reg);
  wire ld_same = ($signed(ld.goal) == pos_reg);
  wire ld_blend_spd = ld.speed_ctl && (ld.pattern == PSS_PATTERN_BLEND_NEXT_STEP);
  wire ld_flip = prev_blend_reg && !ld_same && (ld_fwd != dir_reg);
  wire ld_chain_over = (chain_cnt_reg == `PSS_CHAIN_MAX);

  // where a repeat-method step sends the sequence
  wire [7:0] rep_target = rep_pend_reg ? rep_val_reg : `PSS_STEP_FIRST;
  // successor of the running step
  wire [7:0] succ = act_reg.method_repeat ? rep_target : step_plus_one(run_step_reg);

  // profile arithmetic
  wire signed [31:0] diff   = $signed(act_reg.goal) - pos_reg;
  wire [31:0] remain        = diff[31] ? 32'(-diff) : diff;
  wire [31:0] vel_w         = {16'h0000, vel_reg};
  wire [31:0] brake_dist    = (vel_w * (vel_w + 32'h00000001)) >> 1;
  wire        is_blend      = (act_reg.pattern == PSS_PATTERN_BLEND_NEXT_STEP);
  // blend steps keep speed through the goal; others brake in time
  wire        need_brake    = !is_blend && (brake_dist >= remain);
  wire [15:0] vel_target    = need_brake ? 16'h0000 : act_reg.speed;
  logic [15:0] vel_step;
  always_comb
  begin
    if (vel_reg < vel_target)
      vel_step = vel_reg + 16'h0001;   // acceleration section
    else if (vel_reg > vel_target)
      vel_step = vel_reg - 16'h0001;   // deceleration section
    else
      vel_step = vel_reg;              // constant section
  end
  // never stall short of the goal, never pass it
  wire [15:0] vel_min  = (vel_step == 16'h0000) ? 16'h0001 : vel_step;
  wire [15:0] vel_next = ({16'h0000, vel_min} > remain) ? remain[15:0] : vel_min;
  wire signed [31:0] pos_step = dir_reg ? pos_reg + $signed({16'h0000, vel_next})
                                        : pos_reg - $signed({16'h0000, vel_next});

  // event sources
  logic ev_done;
  logic ev_err;

  // bus front end: address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_reg    <= '0;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      if (hready)
        cap_reg <= '{valid: addr_ok, wr: hwrite, addr: haddr[7:0]};
      if (addr_ok && !hwrite)
        hrdata_reg <= rd_mux;
    end
  end

  // software-written configuration and table
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_step_reg <= 8'h00;
      tbl_idx_reg    <= 8'h00;
      tbl_goal_reg   <= 32'h00000000;
      tbl_dwell_reg  <= 16'h0000;
      irq_mask_reg   <= `PSS_RST_IRQ;
    end
    else
    begin
      if (wr_ctrl)
        start_step_reg <= wr_step;
      if (wr_tidx)
        tbl_idx_reg <= hwdata[7:0];
      if (wr_tgoal)
        tbl_goal_reg <= hwdata;
      if (wr_tdwl)
        tbl_dwell_reg <= hwdata[15:0];
      if (wr_imask)
        irq_mask_reg <= hwdata[1:0];
    end
  end

  // table commit on the configuration write; steps are flip-flops
  always_ff @(posedge hclk)
  begin
    if (wr_tcfg && step_ok(tbl_idx_reg))
      table_reg[tbl_idx_reg] <= '{goal: tbl_goal_reg, speed: hwdata[31:16],
                                  dwell: tbl_dwell_reg,
                                  pattern: pss_pattern_e'(hwdata[1:0]),
                                  method_repeat: hwdata[`PSS_CFG_METHOD_BIT],
                                  speed_ctl: hwdata[`PSS_CFG_SPDCTL_BIT]};
  end

  // tick prescaler
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ms_cnt_reg <= 32'h00000000;
    else
      ms_cnt_reg <= ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_reg <= `PSS_RST_IRQ;
    else
      irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? hwdata[1:0] : 2'h0)) | {ev_err, ev_done};
  end

  // sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg      <= PSS_ST_IDLE;
      cur_step_reg   <= `PSS_RST_STEP;
      run_step_reg   <= `PSS_RST_STEP;
      rep_val_reg    <= `PSS_RST_STEP;
      rep_pend_reg   <= 1'b0;
      act_reg        <= '0;
      prev_blend_reg <= 1'b0;
      chain_cnt_reg  <= 9'h000;
      vel_reg        <= 16'h0000;
      pos_reg        <= 32'sh00000000;
      dir_reg        <= 1'b1;
      dwell_cnt_reg  <= 16'h0000;
      err_code_reg   <= `PSS_ERR_NONE;
      done_reg       <= 1'b0;
      ev_done        <= 1'b0;
      ev_err         <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      ev_done  <= 1'b0;
      ev_err   <= 1'b0;
      // repeat change is taken in any state, even mid-move
      if (wr_rep && step_ok(hwdata[7:0]))
      begin
        rep_val_reg  <= hwdata[7:0];
        rep_pend_reg <= 1'b1;
      end
      case (state_reg)
        PSS_ST_IDLE:
        begin
          if (start_ok)
          begin
            // named step runs regardless; step 0 runs the current one
            run_step_reg   <= (wr_step == 8'h00) ? cur_step_reg : wr_step;
            chain_cnt_reg  <= 9'h000;
            prev_blend_reg <= 1'b0;
            vel_reg        <= 16'h0000;
            err_code_reg   <= `PSS_ERR_NONE;
            state_reg      <= PSS_ST_LOAD;
          end
        end
        PSS_ST_LOAD:
        begin
          cur_step_reg <= run_step_reg;
          if (ld_blend_spd)
          begin
            err_code_reg <= `PSS_ERR_SPD_BLEND;     // refused, not run
            ev_err       <= 1'b1;
            state_reg    <= PSS_ST_IDLE;
          end
          else if (ld_chain_over)
          begin
            // stop with an error and resume later from the repeat step
            err_code_reg <= `PSS_ERR_CHAIN;
            ev_err       <= 1'b1;
            cur_step_reg <= rep_target;
            rep_pend_reg <= 1'b0;
            state_reg    <= PSS_ST_IDLE;
          end
          else if (ld_flip)
          begin
            err_code_reg <= `PSS_ERR_DIR_FLIP;      // blend run reversed
            ev_err       <= 1'b1;
            vel_reg      <= 16'h0000;
            state_reg    <= PSS_ST_IDLE;
          end
          else
          begin
            act_reg       <= ld;
            dir_reg       <= ld_same ? dir_reg : ld_fwd;
            chain_cnt_reg <= chain_cnt_reg + 9'h001;
            if (!prev_blend_reg)
              vel_reg <= 16'h0000;                   // each stop-to-stop move starts at rest
            state_reg     <= PSS_ST_MOVE;
          end
        end
        PSS_ST_MOVE:
        begin
          if (remain == 32'h00000000)
          begin
            if (is_blend)
            begin
              // straight on to the next goal, no dwell
              run_step_reg   <= succ;
              prev_blend_reg <= 1'b1;
              if (act_reg.method_repeat)
                rep_pend_reg <= 1'b0;
              state_reg      <= PSS_ST_LOAD;
            end
            else
            begin
              vel_reg       <= 16'h0000;
              dwell_cnt_reg <= act_reg.dwell;
              state_reg     <= PSS_ST_DWELL;
            end
          end
          else if (ms_tick)
          begin
            vel_reg <= vel_next;                      // trapezoid step
            pos_reg <= pos_step;
          end
        end
        PSS_ST_DWELL:
        begin
          if (dwell_cnt_reg == 16'h0000)
          begin
            prev_blend_reg <= 1'b0;
            if (act_reg.method_repeat)
              rep_pend_reg <= 1'b0;
            if (act_reg.pattern == PSS_PAT_END)
            begin
              // complete only after the dwell
              cur_step_reg <= succ;
              done_reg     <= 1'b1;
              ev_done      <= 1'b1;
              state_reg    <= PSS_ST_IDLE;
            end
            else
            begin
              run_step_reg <= succ;                   // keep: on to succ (step plus one, or the repeat target for a repeat step), no start
              state_reg    <= PSS_ST_LOAD;
            end
          end
          else if (ms_tick)
            dwell_cnt_reg <= dwell_cnt_reg - 16'h0001;
        end
        default:
          state_reg <= PSS_ST_IDLE;
      endcase
    end
  end

  // drive command from flops; a blend hand-over keeps moving high so the
  // drive never sees a stop between intermediate goals
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      motion_reg <= '0;
    else
      motion_reg <= '{moving: (state_reg == PSS_ST_MOVE) ||
                              ((state_reg == PSS_ST_LOAD) && prev_blend_reg),
                      dir_fwd: dir_reg, rate: vel_reg, position: pos_reg};
  end

  // outputs
  assign hreadyout  = 1'b1;                          // zero wait states
  assign hresp      = 1'b0;                          // always OKAY
  assign hrdata     = hrdata_reg;
  assign motion     = motion_reg;
  assign busy       = (state_reg != PSS_ST_IDLE);
  assign done_pulse = done_reg;
  assign irq        = |(irq_stat_reg & irq_mask_reg);

endmodule : pss_sequencer
`default_nettype wire

// ---- test/pss_sequencer_sva.sv ----
// Purpose: port-level assertions for the step sequencer
// Assumes: MS_CYCLES equals the value on the bound instance
// Notes:   bound into every pss_sequencer instance
`timescale 1ns/100ps
`default_nettype none
`include "pss_defines.svh"
module pss_sequencer_sva
  import pss_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 4  // cycles per profile tick
)(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire pss_motion_s motion,
  input wire logic        busy,
  input wire logic        done_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic        ctrl_q;  // control write now in its data phase
  logic [31:0] pos_q;   // position one cycle ago
  logic [15:0] gap;     // cycles since the position last moved
  wire         chg = motion.position != pos_q;

  // helper state; gap saturates so a long pause never wraps
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl_q <= 1'b0;
      pos_q  <= 32'h0000_0000;
      gap    <= 16'hFFFF;
    end
    else
    begin
      ctrl_q <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == `PSS_OFF_CTRL);
      pos_q  <= motion.position;
      gap    <= chg ? 16'h0000 : (gap == 16'hFFFF ? gap : gap + 16'h0001);
    end

  property p_start_busy;
    (ctrl_q && hwdata[0] && hwdata[15:8] == 8'h00 && !busy) |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy did not follow a start");
  property p_move_busy;
    $rose(motion.moving) |-> busy;
  endproperty
  a_move_busy: assert property (p_move_busy)
    else $error("motion began while idle");
  property p_done_once;
    done_pulse |=> !done_pulse;
  endproperty
  a_done_once: assert property (p_done_once)
    else $error("done longer than one cycle");
  property p_done_idle;
    done_pulse |-> !busy;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("done while still busy");
  property p_stop_idle;
    $fell(busy) |-> ##[0:1] !motion.moving;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("still moving after busy fell");
  property p_dir;
    (motion.moving && $past(motion.moving) && chg)
      |-> motion.dir_fwd == ($signed(motion.position) > $signed(pos_q));
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction flag disagrees with travel");
  property p_rate;
    (motion.moving && $past(motion.moving))
      |-> (motion.rate - $past(motion.rate)) inside {16'h0000, 16'h0001, 16'hFFFF};
  endproperty
  a_rate: assert property (p_rate)
    else $error("speed jumped by more than one");
  property p_tick_gap;
    (motion.moving && chg) |-> gap >= MS_CYCLES - 1;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("profile advanced between ticks");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus wait or error response");
endmodule : pss_sequencer_sva

bind pss_sequencer pss_sequencer_sva #(.MS_CYCLES(MS_CYCLES)) u_pss_sequencer_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .motion(motion), .busy(busy), .done_pulse(done_pulse));
`default_nettype wire

// ---- test/pss_servo_model.sv ----
// Purpose: servo drive stand-in that follows the motion command
// Assumes: command is registered in the hclk domain
// Notes:   passive; it only counts and flags what it sees
`timescale 1ns/100ps
`default_nettype none
module pss_servo_model
  import pss_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire pss_motion_s motion,
  input wire logic        done_pulse,
  output logic [7:0]      done_cnt,
  output logic [7:0]      stop_cnt,
  output logic            rev_seen
);
  logic moving_q;  // command one cycle ago

  // counts completions and halts; a halt mid-chain would show as extra stops
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      done_cnt <= 8'h00;
      stop_cnt <= 8'h00;
      rev_seen <= 1'b0;
      moving_q <= 1'b0;
    end
    else
    begin
      done_cnt <= done_cnt + {7'h00, done_pulse};
      stop_cnt <= stop_cnt + {7'h00, moving_q & ~motion.moving};
      rev_seen <= rev_seen | (motion.moving & ~motion.dir_fwd);
      moving_q <= motion.moving;
    end
endmodule : pss_servo_model
`default_nettype wire

// ---- test/tb_pss_sequencer.sv ----
// Purpose: register-level test of the step sequencer
// Assumes: profile tick shortened to 4 cycles
// Notes:   step table written before each use
`timescale 1ns/100ps
`default_nettype none
`include "pss_defines.svh"
module tb_pss_sequencer
  import pss_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy, done_pulse, irq;
  logic [31:0] haddr, hwdata, hrdata, r, p;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  done_cnt, stop_cnt, s;
  logic        rev_seen;
  wire logic   hready = hreadyout;  // single slave drives bus ready
  pss_motion_s motion;
  int          fails, checks_done, n;

  pss_sequencer #(.MS_CYCLES(4)) u_pss_sequencer (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .motion(motion), .busy(busy), .done_pulse(done_pulse), .irq(irq));
  pss_servo_model u_pss_servo_model (.hclk(hclk), .hresetn(hresetn), .motion(motion),
    .done_pulse(done_pulse), .done_cnt(done_cnt), .stop_cnt(stop_cnt), .rev_seen(rev_seen));

  // 50 ns clock
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic finish_test();
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for ready; the watchdog ends a real hang
  task automatic wait_rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hready !== 1'b1 && k < 50);
  endtask : wait_rdy

  // one single AHB transfer; read data left in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0000_0000);
    chk(r & m, exp);
  endtask : rd

  task automatic step(input logic [7:0] i, input logic [31:0] g, input logic [15:0] dw,
                      input pss_pattern_e pat, input logic rep, input logic spd);
    bus(1'b1, `PSS_OFF_TBL_INDEX, {24'h000000, i});
    bus(1'b1, `PSS_OFF_TBL_GOAL, g);
    bus(1'b1, `PSS_OFF_TBL_DWELL, {16'h0000, dw});
    bus(1'b1, `PSS_OFF_TBL_CFG, {16'h0002, 12'h000, spd, rep, pat});
  endtask : step

  // start, then let the launching edge land before looking at busy
  task automatic start(input logic [7:0] st);
    bus(1'b1, `PSS_OFF_CTRL, {16'h0000, st, 8'h01});
    @(posedge hclk);
  endtask : start

  task automatic idle();
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000)
      chk(32'h0000_0000, 32'h0000_0001);
    // let the closing edge's counter updates land before anyone looks
    @(posedge hclk);
  endtask : idle

  // watchdog: whole run needs well under 20000 cycles
  initial
  begin
    #(60000 * 50);
    fails++;
    finish_test();
  end

  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize   = 3'h2;
    hresetn = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(`PSS_OFF_STATUS, 32'h0000_0100, 32'h03FF_FF01);
    rd(`PSS_OFF_IRQ_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    step(8'h01, 32'h3, 16'h1, PSS_PAT_END, 1'b0, 1'b0);
    step(8'h02, 32'h1, 16'h0, PSS_PAT_END, 1'b1, 1'b0);
    step(8'h03, 32'h4, 16'h0, PSS_PAT_END, 1'b1, 1'b0);
    step(8'h0A, 32'h6, 16'h1, PSS_PAT_KEEP, 1'b0, 1'b0);
    step(8'h0B, 32'h8, 16'h0, PSS_PAT_END, 1'b0, 1'b0);
    step(8'h14, 32'hA, 16'h0, PSS_PATTERN_BLEND_NEXT_STEP, 1'b0, 1'b0);
    step(8'h15, 32'h9, 16'h0, PSS_PATTERN_BLEND_NEXT_STEP, 1'b0, 1'b0);
    step(8'h16, 32'h9, 16'h0, PSS_PAT_END, 1'b0, 1'b0);
    step(8'h1E, 32'hC, 16'h0, PSS_PATTERN_BLEND_NEXT_STEP, 1'b0, 1'b1);
    bus(1'b1, `PSS_OFF_IRQ_MASK, 32'h0000_0003);
    // single end step, then interrupt raise and clear
    start(8'h00);
    idle();
    rd(`PSS_OFF_POSITION, 32'h0000_0003, 32'hFFFF_FFFF);
    rd(`PSS_OFF_STATUS, 32'h0000_0200, 32'h0000_FF01);
    chk({24'h0, done_cnt}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(`PSS_OFF_IRQ_STAT, 32'h0000_0001, 32'h0000_0003);
    bus(1'b1, `PSS_OFF_IRQ_STAT, 32'h0000_0001);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    // reverse repeat step with no change command returns to step 1
    start(8'h00);
    idle();
    chk({31'h0, rev_seen}, 32'h0000_0001);
    rd(`PSS_OFF_STATUS, 32'h0000_0100, 32'h0000_FF01);
    // indirect start, change command while moving
    start(8'h03);
    chk({31'h0, busy}, 32'h0000_0001);
    bus(1'b1, `PSS_OFF_REP_STEP, 32'h0000_000A);
    idle();
    rd(`PSS_OFF_POSITION, 32'h0000_0004, 32'hFFFF_FFFF);
    rd(`PSS_OFF_STATUS, 32'h0000_0A00, 32'h0000_FF01);
    rd(`PSS_OFF_REP_STEP, 32'h0000_0000, 32'h0000_0100);
    // keep chain runs two steps on one start
    start(8'h00);
    idle();
    chk({24'h0, done_cnt}, 32'h0000_0004);
    rd(`PSS_OFF_POSITION, 32'h0000_0008, 32'hFFFF_FFFF);
    rd(`PSS_OFF_STATUS, 32'h0000_0C00, 32'h0000_FF01);
    // direction flip inside a blend run
    start(8'h14);
    idle();
    rd(`PSS_OFF_STATUS, 32'h01FF_0000, 32'h03FF_0000);
    rd(`PSS_OFF_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    chk({24'h0, done_cnt}, 32'h0000_0004);
    bus(1'b0, `PSS_OFF_POSITION, 32'h0000_0000);
    p = r;
    // speed-control blend step is refused
    start(8'h1E);
    idle();
    rd(`PSS_OFF_STATUS, 32'h00EC_0000, 32'h03FF_0000);
    rd(`PSS_OFF_POSITION, p, 32'hFFFF_FFFF);
    // blend passes its goal without stop; its long dwell is skipped
    step(8'h28, p + 32'h3, 16'h0032, PSS_PATTERN_BLEND_NEXT_STEP, 1'b0, 1'b0);
    step(8'h29, p + 32'h6, 16'h0000, PSS_PAT_END, 1'b0, 1'b0);
    s = stop_cnt;
    start(8'h28);
    idle();
    chk({31'h0, n < 150}, 32'h0000_0001);
    chk({24'h0, stop_cnt}, {24'h0, s + 8'h01});
    rd(`PSS_OFF_POSITION, p + 32'h6, 32'hFFFF_FFFF);
    rd(`PSS_OFF_STATUS, 32'h0000_0000, 32'h03FF_0001);
    // a keep chain with no end step stops after 400 steps, then points at step 1
    for (int i = 1; i <= 150; i++)
      step(8'(i), p + 32'h6, 16'h0000, PSS_PAT_KEEP, 1'b0, 1'b0);
    start(8'h01);
    idle();
    rd(`PSS_OFF_STATUS, 32'h00E0_0100, 32'h03FF_FF01);
    rd(`PSS_OFF_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    finish_test();
  end
endmodule : tb_pss_sequencer
`default_nettype wire
